// ### core/asc_pkg.sv
// shared constants for the converter sequencer control block
package asc_pkg;
   // register addresses on the special-function-register bus
   localparam logic [7:0] POS_SEL_ADDR  = 8'hbb;  // positive_channel_select
   localparam logic [7:0] NEG_SEL_ADDR  = 8'hba;  // negative_channel_select
   localparam logic [7:0] CONFIG_ADDR   = 8'hbc;  // converter_configuration
   localparam logic [7:0] RES_LO_ADDR   = 8'hbd;  // result_low_byte
   localparam logic [7:0] RES_HI_ADDR   = 8'hbe;  // result_high_byte
   localparam logic [7:0] CONTROL_ADDR  = 8'he8;  // converter_control

   // reset values
   localparam logic [7:0] POS_SEL_RST   = 8'h00;
   localparam logic [7:0] NEG_SEL_RST   = 8'h00;
   localparam logic [7:0] CONFIG_RST    = 8'hf8;
   localparam logic [7:0] RES_RST       = 8'h00;
   localparam logic [7:0] CONTROL_RST   = 8'h00;

   // field layout
   localparam int         SEL_W         = 5;      // channel selection width
   localparam logic [4:0] GND_CODE      = 5'h1f;  // negative input at ground
   localparam int         DIV_MSB       = 7;      // clock_divider_field bits 7..3
   localparam int         DIV_LSB       = 3;
   localparam int         JUST_BIT      = 2;      // justify_select
   localparam int         EN_BIT        = 7;      // converter_enable
   localparam int         TM_BIT        = 6;      // track_mode_bit
   localparam int         INT_BIT       = 5;      // conversion_complete_flag
   localparam int         BUSY_BIT      = 4;      // busy_bit
   localparam int         WIN_BIT       = 3;      // window_match_flag
   localparam int         CM_MSB        = 2;      // start_mode_field bits 2..0

   // start_mode_field codes
   localparam logic [2:0] CM_BUSY       = 3'h0;
   localparam logic [2:0] CM_TIMER0     = 3'h1;
   localparam logic [2:0] CM_TIMER2     = 3'h2;
   localparam logic [2:0] CM_TIMER1     = 3'h3;
   localparam logic [2:0] CM_EXT_PIN    = 3'h4;
   localparam logic [2:0] CM_TIMER3     = 3'h5;

   // timing in converter clocks, and result width
   localparam int         TRACK_CLOCKS  = 3;      // low-power tracking phase
   localparam int         CONV_CLOCKS   = 10;     // conversion length
   localparam int         CODE_W        = 10;     // result width

   // sequencer states, gray along idle -> track -> convert
   typedef enum logic [1:0] {
      ASC_IDLE  = 2'b00,
      ASC_TRACK = 2'b01,
      ASC_CONV  = 2'b11
   } asc_state_t;
endpackage

// ### core/asc_clkdiv.sv
// converter clock divider: one-cycle tick every (divide + 1) system clocks
`timescale 1ns/1ns
module asc_clkdiv
   import asc_pkg::*;
#(
   parameter int DIV_W = 5                    // width of the divide value
) (
   input  wire logic             clk,         // system clock
   input  wire logic             rst,         // synchronous reset, high
   input  wire logic             ce,          // clock enable, freezes state
   input  wire logic             run,         // divider runs while high
   input  wire logic [DIV_W-1:0] divide,      // divide value minus one
   output logic                  tick         // one-cycle converter clock pulse
);
   logic [DIV_W-1:0] cnt_reg;                 // cycles since last tick
   logic [DIV_W-1:0] cnt_next;
   logic             wrap;                    // count reached the divide value

   if (DIV_W < 1) begin : g_chk
      $error("asc_clkdiv: DIV_W must be at least 1");
   end

   assign wrap     = (cnt_reg >= divide);
   assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;
   assign tick     = run && wrap;

   // counter restarts when stopped so each phase starts aligned
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= run ? cnt_next : '0;
      end
   end
endmodule

// ### core/asc_ctrl.sv
// converter sequencer control: registers, trigger select, tracking and result format
// Behaviour
// - channel selects five bits, upper bits zero
// - ground negative code means single-ended, else differential
// - converter clock is system clock over divider+1
// - justify bit picks right or left layout
// - right layout: high byte sign extends bit1
// - right layout: low byte holds low eight bits
// - left layout: high eight bits, low two
// - configuration low two bits read zero
// - enable low means shutdown, no conversions
// - normal mode tracks except while converting
// - busy while converting; falling edge sets complete
// - busy write starts only in mode 000
// - window match sets sticky flag
// - start mode selects one of six triggers
// - low-power: three converter clocks tracking first
// - low-power pin mode: track low, convert rising
// - timer 2/3 overflow byte follows split mode
// - conversion lasts ten converter clocks
// - differential signed, single-ended unsigned result
`timescale 1ns/1ns
module asc_ctrl
   import asc_pkg::*;
#(
   parameter int TRACK_LEN = TRACK_CLOCKS,    // low-power tracking, converter clocks
   parameter int CONV_LEN  = CONV_CLOCKS      // conversion length, converter clocks
) (
   input  wire logic              REF_CLK,       // system clock, 10 MHz
   input  wire logic              RST,           // synchronous reset, high
   input  wire logic              CE,            // clock enable
   input  wire logic [7:0]        SFR_ADDR,      // register address
   input  wire logic              SFR_WR,        // write strobe
   input  wire logic [7:0]        SFR_WDATA,     // write data
   input  wire logic              SFR_RD,        // read strobe
   output logic      [7:0]        SFR_RDATA,     // read data, one cycle after strobe
   input  wire logic              T0_OVF,        // timer 0 overflow pulse
   input  wire logic              T1_OVF,        // timer 1 overflow pulse
   input  wire logic              T2_LO_OVF,     // timer 2 low byte overflow
   input  wire logic              T2_HI_OVF,     // timer 2 high byte overflow
   input  wire logic              T2_SPLIT,      // timer 2 in 8-bit mode
   input  wire logic              T3_LO_OVF,     // timer 3 low byte overflow
   input  wire logic              T3_HI_OVF,     // timer 3 high byte overflow
   input  wire logic              T3_SPLIT,      // timer 3 in 8-bit mode
   input  wire logic              EXT_START,     // external_start_pin level
   input  wire logic              WINDOW_MATCH,  // window comparator hit pulse
   input  wire logic [CODE_W-1:0] CODE_IN,       // raw code from the analog core
   output logic                   POWER_ON,      // analog core powered
   output logic                   TRACK,         // track-and-hold in track
   output logic                   CONVERTING,    // analog core converting
   output logic                   SAR_TICK,      // converter clock pulse
   output logic                   DIFF_MODE,     // differential operation
   output logic      [SEL_W-1:0]  POS_SEL,       // positive input selection
   output logic      [SEL_W-1:0]  NEG_SEL        // negative input selection
);
   // elaboration checks on lengths the counter can serve
   if (TRACK_LEN < 1 || TRACK_LEN > 15 || CONV_LEN < 1 || CONV_LEN > 15) begin : g_chk
      $error("asc_ctrl: phase lengths must lie in 1..15");
   end

   // register storage
   logic [SEL_W-1:0] pos_reg;                 // positive selection
   logic [SEL_W-1:0] neg_reg;                 // negative selection
   logic [4:0]       div_reg;                 // clock_divider_field
   logic             just_reg;                // justify_select
   logic             en_reg;                  // converter_enable
   logic             tm_reg;                  // track_mode_bit
   logic             int_reg;                 // conversion_complete_flag
   logic             win_reg;                 // window_match_flag
   logic [2:0]       cm_reg;                  // start_mode_field
   logic [7:0]       res_hi_reg;              // result_high_byte
   logic [7:0]       res_lo_reg;              // result_low_byte
   logic [7:0]       rdata_reg;               // registered read data
   logic             pin_prev_reg;            // external pin one cycle ago
   logic [3:0]       phase_cnt_reg;           // converter clocks into the phase
   asc_state_t       state_reg;
   asc_state_t       state_next;
   logic             busy;                    // tracking phase or conversion running
   logic             diff;                    // differential when negative not ground
   logic             idle;                    // sequencer waiting for a trigger

   // bus decode
   logic wr_pos, wr_neg, wr_cfg, wr_lo, wr_hi, wr_ctl;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
      hit = (addr == offs);
   endfunction

   assign wr_pos = SFR_WR && hit(SFR_ADDR, POS_SEL_ADDR);
   assign wr_neg = SFR_WR && hit(SFR_ADDR, NEG_SEL_ADDR);
   assign wr_cfg = SFR_WR && hit(SFR_ADDR, CONFIG_ADDR);
   assign wr_lo  = SFR_WR && hit(SFR_ADDR, RES_LO_ADDR);
   assign wr_hi  = SFR_WR && hit(SFR_ADDR, RES_HI_ADDR);
   assign wr_ctl = SFR_WR && hit(SFR_ADDR, CONTROL_ADDR);

   // readback images
   wire  [7:0] ctl_image = {en_reg, tm_reg, int_reg, busy, win_reg, cm_reg};
   wire  [7:0] cfg_image = {div_reg, just_reg, 2'b00};
   wire  [7:0] pos_image = {3'b000, pos_reg};
   wire  [7:0] neg_image = {3'b000, neg_reg};
   logic [7:0] rd_mux;

   assign rd_mux = hit(SFR_ADDR, POS_SEL_ADDR) ? pos_image :
                   hit(SFR_ADDR, NEG_SEL_ADDR) ? neg_image :
                   hit(SFR_ADDR, CONFIG_ADDR)  ? cfg_image :
                   hit(SFR_ADDR, RES_LO_ADDR)  ? res_lo_reg :
                   hit(SFR_ADDR, RES_HI_ADDR)  ? res_hi_reg :
                   hit(SFR_ADDR, CONTROL_ADDR) ? ctl_image : 8'h00;

   // operating mode

   assign idle = (state_reg == ASC_IDLE);
   assign busy = !idle;
   assign diff = (neg_reg != GND_CODE);

   // trigger selection
   logic pin_rise;                            // rising edge of external pin
   logic t2_ovf;                              // timer 2 overflow per its mode
   logic t3_ovf;                              // timer 3 overflow per its mode
   logic busy_write;                          // software start
   logic trig;                                // selected trigger this cycle
   logic pin_mode;                            // pin start selected

   assign pin_rise   = EXT_START && !pin_prev_reg;
   assign t2_ovf     = T2_SPLIT ? T2_LO_OVF : T2_HI_OVF;
   assign t3_ovf     = T3_SPLIT ? T3_LO_OVF : T3_HI_OVF;
   assign busy_write = wr_ctl && SFR_WDATA[BUSY_BIT] && (cm_reg == CM_BUSY);
   assign pin_mode   = (cm_reg == CM_EXT_PIN);

   // codes 11x select nothing, so those settings never start
   always_comb begin
      case (cm_reg)
         CM_BUSY:    trig = busy_write;
         CM_TIMER0:  trig = T0_OVF;
         CM_TIMER2:  trig = t2_ovf;
         CM_TIMER1:  trig = T1_OVF;
         CM_EXT_PIN: trig = pin_rise;
         CM_TIMER3:  trig = t3_ovf;
         default:    trig = 1'b0;
      endcase
   end

   // converter clock divider, stopped while idle so phases start aligned
   logic tick;

   asc_clkdiv #(
      .DIV_W  (5)
   ) u_div (
      .clk    (REF_CLK),
      .rst    (RST),
      .ce     (CE),
      .run    (busy),
      .divide (div_reg),
      .tick   (tick)
   );

   // sequencer
   logic track_done;                          // last tracking clock
   logic conv_done;                           // last conversion clock
   logic start;                               // accepted trigger

   assign track_done = tick && (phase_cnt_reg == 4'(TRACK_LEN - 1));
   assign conv_done  = tick && (phase_cnt_reg == 4'(CONV_LEN - 1));
   assign start      = en_reg && idle && trig;

   // low-power pin mode skips the timed tracking phase: the pin low time is the track
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ASC_IDLE: begin
            if (start) begin
               state_next = (tm_reg && !pin_mode) ? ASC_TRACK : ASC_CONV;
            end
         end
         ASC_TRACK: begin
            if (track_done) begin
               state_next = ASC_CONV;
            end
         end
         ASC_CONV: begin
            if (conv_done) begin
               state_next = ASC_IDLE;
            end
         end
         default: begin
            state_next = ASC_IDLE;
         end
      endcase
      if (!en_reg) begin
         state_next = ASC_IDLE;
      end
   end

   // result formatting, shared by both layouts
   function automatic logic [15:0] fmt(input logic [CODE_W-1:0] code,
                                       input logic left, input logic signed_code);
      logic ext;
      ext = signed_code & code[CODE_W-1];
      if (left) begin
         fmt = {code, 6'h00};
      end else begin
         fmt = {{6{ext}}, code};
      end
   endfunction

   logic [15:0] result_word;                  // formatted result to store

   assign result_word = fmt(CODE_IN, just_reg, diff);

   // state and phase counter
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_reg     <= ASC_IDLE;
         phase_cnt_reg <= 4'h0;
      end else if (CE) begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            phase_cnt_reg <= 4'h0;
         end else if (tick) begin
            phase_cnt_reg <= phase_cnt_reg + 4'h1;
         end
      end
   end

   // edge history of the external pin
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pin_prev_reg <= 1'b0;
      end else if (CE) begin
         pin_prev_reg <= EXT_START;
      end
   end

   // channel selects and configuration; unused bits never stored
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         pos_reg  <= POS_SEL_RST[SEL_W-1:0];
         neg_reg  <= NEG_SEL_RST[SEL_W-1:0];
         div_reg  <= CONFIG_RST[DIV_MSB:DIV_LSB];
         just_reg <= CONFIG_RST[JUST_BIT];
      end else if (CE) begin
         if (wr_pos) begin
            pos_reg <= SFR_WDATA[SEL_W-1:0];
         end
         if (wr_neg) begin
            neg_reg <= SFR_WDATA[SEL_W-1:0];
         end
         if (wr_cfg) begin
            div_reg  <= SFR_WDATA[DIV_MSB:DIV_LSB];
            just_reg <= SFR_WDATA[JUST_BIT];
         end
      end
   end

   // control bits; hardware set of a flag beats a same-cycle software clear
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         en_reg  <= CONTROL_RST[EN_BIT];
         tm_reg  <= CONTROL_RST[TM_BIT];
         int_reg <= CONTROL_RST[INT_BIT];
         win_reg <= CONTROL_RST[WIN_BIT];
         cm_reg  <= CONTROL_RST[CM_MSB:0];
      end else if (CE) begin
         if (wr_ctl) begin
            en_reg  <= SFR_WDATA[EN_BIT];
            tm_reg  <= SFR_WDATA[TM_BIT];
            cm_reg  <= SFR_WDATA[CM_MSB:0];
            int_reg <= SFR_WDATA[INT_BIT];
            win_reg <= SFR_WDATA[WIN_BIT];
         end
         if (state_reg == ASC_CONV && conv_done && en_reg) begin
            int_reg <= 1'b1;
         end
         if (WINDOW_MATCH) begin
            win_reg <= 1'b1;
         end
      end
   end

   // result bytes: loaded at completion, else writable by software
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         res_hi_reg <= RES_RST;
         res_lo_reg <= RES_RST;
      end else if (CE) begin
         if (state_reg == ASC_CONV && conv_done && en_reg) begin
            res_hi_reg <= result_word[15:8];
            res_lo_reg <= result_word[7:0];
         end else begin
            if (wr_hi) begin
               res_hi_reg <= SFR_WDATA;
            end
            if (wr_lo) begin
               res_lo_reg <= SFR_WDATA;
            end
         end
      end
   end

   // registered read port keeps the data output glitch free
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rdata_reg <= 8'h00;
      end else if (CE && SFR_RD) begin
         rdata_reg <= rd_mux;
      end
   end

   // outputs to the analog core
   logic track_lp;                            // low-power tracking request

   assign track_lp   = (state_reg == ASC_TRACK) ||
                       (idle && pin_mode && !EXT_START);
   assign TRACK      = en_reg && (tm_reg ? track_lp : (state_reg != ASC_CONV));
   assign CONVERTING = (state_reg == ASC_CONV);
   assign POWER_ON   = en_reg;
   assign SAR_TICK   = tick;
   assign DIFF_MODE  = diff;
   assign POS_SEL    = pos_reg;
   assign NEG_SEL    = neg_reg;
   assign SFR_RDATA  = rdata_reg;
endmodule

// ### verif/asc_ctrl_props.sv
// property checker for the converter sequencer control block
`timescale 1ns/1ns
module asc_ctrl_props
   import asc_pkg::*;
#(
   parameter int TRACK_LEN = TRACK_CLOCKS,  // tracking length, converter clocks
   parameter int CONV_LEN  = CONV_CLOCKS    // conversion length, converter clocks
) (
   input wire logic             REF_CLK,     // system clock
   input wire logic             RST,         // reset, high
   input wire logic             CE,          // clock enable
   input wire logic [7:0]       SFR_ADDR,    // register address
   input wire logic             SFR_WR,      // write strobe
   input wire logic [7:0]       SFR_WDATA,   // write data
   input wire logic             SFR_RD,      // read strobe
   input wire logic [7:0]       SFR_RDATA,   // read data
   input wire logic             POWER_ON,    // converter enabled
   input wire logic             TRACK,       // tracking
   input wire logic             CONVERTING,  // converting
   input wire logic             SAR_TICK,    // converter clock pulse
   input wire logic             DIFF_MODE,   // differential flag
   input wire logic [SEL_W-1:0] NEG_SEL      // negative selection
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // converter clocks per phase; an off-by-one in the sequencer shows as a wrong total
   logic [4:0] conv_cnt_reg, conv_cnt_next;  // ticks in this conversion
   logic [4:0] trk_cnt_reg, trk_cnt_next;    // ticks in this tracking phase
   logic [3:0] mode_sh_reg;                  // stored track mode and start mode
   assign conv_cnt_next = CONVERTING ? conv_cnt_reg + 5'(SAR_TICK) : 5'h00;
   assign trk_cnt_next  = TRACK ? trk_cnt_reg + 5'(SAR_TICK) : 5'h00;

   // counters restart whenever their phase is over
   always_ff @(posedge REF_CLK) begin
      conv_cnt_reg <= RST ? 5'h00 : conv_cnt_next;
      trk_cnt_reg  <= RST ? 5'h00 : trk_cnt_next;
   end

   // a busy write is judged by the mode bits stored before it
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mode_sh_reg <= 4'h0;
      end else if (CE && SFR_WR && (SFR_ADDR == CONTROL_ADDR)) begin
         mode_sh_reg <= {SFR_WDATA[TM_BIT], SFR_WDATA[CM_MSB:0]};
      end
   end

   sequence s_ctl_wr;
      CE && SFR_WR && (SFR_ADDR == CONTROL_ADDR);
   endsequence
   sequence s_rd(logic [7:0] a);
      CE && SFR_RD && (SFR_ADDR == a);
   endsequence
   sequence s_busy_go;
      SFR_WDATA[EN_BIT] && SFR_WDATA[BUSY_BIT] && POWER_ON && mode_sh_reg == 4'h0 && !CONVERTING;
   endsequence
   sequence s_busy_stray;
      SFR_WDATA[BUSY_BIT] && mode_sh_reg[2:1] == 2'b11 && !CONVERTING;
   endsequence
   sequence s_conv_run;
      CONVERTING && !TRACK ##1 CONVERTING;
   endsequence

   AST_DIFF_MODE: assert property (DIFF_MODE == (NEG_SEL != GND_CODE))
      else $error("differential flag disagrees with negative select");
   AST_SHUTDOWN: assert property (!POWER_ON ##1 !POWER_ON |-> !CONVERTING && !TRACK && !SAR_TICK)
      else $error("activity while disabled");
   AST_ENABLE_BIT: assert property (s_ctl_wr |=> POWER_ON == $past(SFR_WDATA[EN_BIT]))
      else $error("enable output does not follow control write");
   AST_BUSY_START: assert property (s_ctl_wr ##0 s_busy_go |=> s_conv_run)
      else $error("busy write did not start a conversion");
   AST_BUSY_OTHER_MODE: assert property (s_ctl_wr ##0 s_busy_stray |=> !CONVERTING)
      else $error("busy write started outside mode zero");
   AST_CONV_TICKS: assert property ($fell(CONVERTING) && POWER_ON |-> conv_cnt_reg == 5'(CONV_LEN))
      else $error("conversion length wrong");
   AST_TRACK_TICKS: assert property ($rose(CONVERTING) |-> trk_cnt_reg inside {5'h00, 5'(TRACK_LEN)})
      else $error("tracking phase length wrong");
   AST_NO_TRACK_IN_CONV: assert property (CONVERTING |-> !TRACK)
      else $error("tracking during conversion");
   AST_SEL_UPPER_ZERO: assert property (s_rd(POS_SEL_ADDR) or s_rd(NEG_SEL_ADDR) |=> SFR_RDATA[7:5] == 3'h0)
      else $error("channel select upper bits not zero");
   AST_CFG_LOW_ZERO: assert property (s_rd(CONFIG_ADDR) |=> SFR_RDATA[1:0] == 2'h0)
      else $error("configuration low bits not zero");
endmodule

bind asc_ctrl asc_ctrl_props #(.TRACK_LEN(TRACK_LEN), .CONV_LEN(CONV_LEN)) u_asc_ctrl_props (
   .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
   .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .POWER_ON(POWER_ON), .TRACK(TRACK), .CONVERTING(CONVERTING),
   .SAR_TICK(SAR_TICK), .DIFF_MODE(DIFF_MODE), .NEG_SEL(NEG_SEL));

// ### verif/tb.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ns
module tb;
   import asc_pkg::*;
   typedef struct packed {
      logic [9:0] code;  // core code
      logic [4:0] neg;   // negative select
      logic       lj;    // justify
      logic [4:0] div;   // divider field
      logic [7:0] hi;    // expected high byte
      logic [7:0] lo;    // expected low byte
   } asc_row_t;
   // ordinary conversions; sign extension only where differential
   asc_row_t   rows [7] = '{
      '{10'h3ff, 5'h1f, 1'h0, 5'h00, 8'h03, 8'hff}, '{10'h3ff, 5'h00, 1'h0, 5'h02, 8'hff, 8'hff},
      '{10'h100, 5'h1e, 1'h0, 5'h00, 8'h01, 8'h00}, '{10'h200, 5'h05, 1'h0, 5'h01, 8'hfe, 8'h00},
      '{10'h3ff, 5'h1f, 1'h1, 5'h00, 8'hff, 8'hc0}, '{10'h100, 5'h00, 1'h1, 5'h00, 8'h40, 8'h00},
      '{10'h200, 5'h1f, 1'h0, 5'h00, 8'h02, 8'h00}};
   // trigger input owned by each start mode, index is the mode
   logic [5:0] right [8] = '{6'h00, 6'h01, 6'h04, 6'h02, 6'h00, 6'h20, 6'h00, 6'h00};
   // reset image, last address unmapped
   logic [7:0] rst_addr [7] = '{POS_SEL_ADDR, NEG_SEL_ADDR, CONFIG_ADDR, RES_LO_ADDR, RES_HI_ADDR,
                                CONTROL_ADDR, 8'hc5};
   logic [7:0] rst_val [7] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
   logic       ref_clk, rst, ce, wr_s, rd_s, ext, win, t2_split, t3_split;
   logic [7:0] addr, wdata, rdata;
   logic [5:0] trg;  // t3 hi, t3 lo, t2 hi, t2 lo, t1, t0
   logic [9:0] code;
   logic [4:0] pos_sel, neg_sel;
   logic       power_on, track, converting, sar_tick, diff_mode;
   int         err_total = 0, samples_checked = 0, n;

   asc_ctrl u_asc_ctrl (
      .REF_CLK(ref_clk), .RST(rst), .CE(ce), .SFR_ADDR(addr), .SFR_WR(wr_s), .SFR_WDATA(wdata),
      .SFR_RD(rd_s), .SFR_RDATA(rdata), .T0_OVF(trg[0]), .T1_OVF(trg[1]), .T2_LO_OVF(trg[2]),
      .T2_HI_OVF(trg[3]), .T2_SPLIT(t2_split), .T3_LO_OVF(trg[4]), .T3_HI_OVF(trg[5]),
      .T3_SPLIT(t3_split), .EXT_START(ext), .WINDOW_MATCH(win), .CODE_IN(code), .POWER_ON(power_on),
      .TRACK(track), .CONVERTING(converting), .SAR_TICK(sar_tick), .DIFF_MODE(diff_mode),
      .POS_SEL(pos_sel), .NEG_SEL(neg_sel));

   // 10 MHz system clock
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle write strobe, taken at the rising edge in between
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr_s = 1'h1;
      @(negedge ref_clk);
      wr_s = 1'h0;
   endtask

   // read data lands one cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
      @(negedge ref_clk);
      addr = a;
      rd_s = 1'h1;
      @(negedge ref_clk);
      rd_s = 1'h0;
      chk(what, rdata, e);
   endtask

   task automatic pulse(input logic [5:0] m, input logic e);
      @(negedge ref_clk);
      trg = m;
      ext = e;
      @(negedge ref_clk);
      trg = 6'h00;
      ext = 1'h0;
   endtask

   // cycles while the watched phase lasts, bounded so a hang still ends
   task automatic run_len(input logic sel, output int c);
      c = 0;
      while (((sel ? track : converting) === 1'h1) && (c < 1000)) begin
         @(negedge ref_clk);
         c++;
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if ((err_total == 0) && (samples_checked > 0)) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #1000000;
      err_total++;
      complete_run();
   end

   initial begin
      {rst, ce, wr_s, rd_s, ext, win, t2_split, t3_split} = 8'hc2;  // timer 2 split, timer 3 not
      {addr, wdata, trg, code} = 32'h0;
      repeat (16) @(negedge ref_clk);
      rst = 1'h0;
      wr(CONTROL_ADDR, 8'h80);
      foreach (rows[i]) begin
         code = rows[i].code;
         wr(NEG_SEL_ADDR, {3'h7, rows[i].neg});
         wr(CONFIG_ADDR, {rows[i].div, rows[i].lj, 2'h3});
         chk("diff mode", diff_mode, rows[i].neg != GND_CODE);
         chk("neg select", neg_sel, rows[i].neg);
         wr(CONTROL_ADDR, 8'h90);
         chk("track in conversion", track, 1'h0);
         run_len(1'h0, n);
         chk("conversion cycles", 16'(n), 16'(CONV_CLOCKS * (rows[i].div + 1)));
         rdc(RES_HI_ADDR, rows[i].hi, "result high");
         rdc(RES_LO_ADDR, rows[i].lo, "result low");
         rdc(CONTROL_ADDR, 8'ha0, "complete flag");
         wr(CONTROL_ADDR, 8'h80);
         rdc(CONTROL_ADDR, 8'h80, "flag cleared");
         chk("idle tracking", track, 1'h1);
         rdc(NEG_SEL_ADDR, {3'h0, rows[i].neg}, "neg upper bits");
         rdc(CONFIG_ADDR, {rows[i].div, rows[i].lj, 2'h0}, "config low bits");
      end
      // every start mode but busy write (000): stray sources first, then its own, then a drop while busy
      for (int cm = 1; cm < 8; cm++) begin
         wr(CONTROL_ADDR, 8'h80 | 8'(cm));
         pulse(~right[cm], cm != 4);
         chk("stray trigger", converting, 1'h0);
         pulse(right[cm], cm == 4);
         chk("selected trigger", converting, cm < 6);
         pulse(6'h3f, 1'h1);
         run_len(1'h0, n);
         chk("trigger not queued", 16'(n), (cm < 6) ? 16'h8 : 16'h0);
      end
      wr(CONTROL_ADDR, 8'hc1);
      chk("low power idle", track, 1'h0);
      pulse(6'h01, 1'h0);
      run_len(1'h1, n);
      chk("tracking clocks", 16'(n), 16'(TRACK_CLOCKS));
      chk("conversion follows", converting, 1'h1);
      run_len(1'h0, n);
      chk("low power conversion", 16'(n), 16'(CONV_CLOCKS));
      wr(CONTROL_ADDR, 8'hc4);
      chk("pin low tracks", track, 1'h1);
      pulse(6'h00, 1'h1);
      chk("pin rise converts", {track, converting}, 2'h1);
      run_len(1'h0, n);
      chk("pin conversion", 16'(n), 16'(CONV_CLOCKS));
      wr(CONTROL_ADDR, 8'h10);
      wr(CONTROL_ADDR, 8'h10);
      chk("disabled busy write", {power_on, converting, track}, 3'h0);
      wr(CONTROL_ADDR, 8'h86);
      wr(CONTROL_ADDR, 8'h96);
      chk("busy write other mode", converting, 1'h0);
      // slow divider, then abort by clearing enable mid-conversion
      wr(CONFIG_ADDR, 8'hf8);
      wr(CONTROL_ADDR, 8'h80);
      wr(CONTROL_ADDR, 8'h90);
      repeat (40) @(negedge ref_clk);
      chk("slow conversion runs", converting, 1'h1);
      wr(CONTROL_ADDR, 8'h00);
      rdc(CONTROL_ADDR, 8'h00, "abort leaves no flag");
      @(negedge ref_clk);
      win = 1'h1;
      @(negedge ref_clk);
      win = 1'h0;
      rdc(CONTROL_ADDR, 8'h08, "window flag");
      wr(CONTROL_ADDR, 8'h00);
      rdc(CONTROL_ADDR, 8'h00, "window flag cleared");
      wr(POS_SEL_ADDR, 8'hff);
      chk("pos select", pos_sel, 5'h1f);
      rdc(POS_SEL_ADDR, 8'h1f, "pos upper bits");
      wr(8'hc5, 8'h5a);
      // second reset while a conversion runs
      wr(CONTROL_ADDR, 8'h80);
      wr(CONTROL_ADDR, 8'h90);
      rst = 1'h1;
      repeat (16) @(negedge ref_clk);
      rst = 1'h0;
      foreach (rst_addr[i]) begin
         rdc(rst_addr[i], rst_val[i], "reset value");
      end
      chk("reset outputs", {power_on, track, converting, diff_mode}, 4'h1);
      complete_run();
   end
endmodule
